// ===== design/scfm_serial_channel.sv
`timescale 1ns/1ps
module scfm_serial_channel
  import scfm_pkg::*;
#(
  parameter int BIT_CYC = SCFM_BIT_CYC,
  parameter int SCLK_HALF_CYC = SCFM_SCLK_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire scfm_bus_req_type bus_req,
  output logic [7:0] bus_rdata,
  output logic irq,
  output logic serial_out_pin,
  input wire logic serial_in_pin,
  input wire logic shift_clock_pin_i,
  output logic shift_clock_pin_o,
  output logic shift_clock_pin_oe
);

  typedef struct packed {
    logic [7:0] mode0;
    logic fdpx;
    logic rb8;
    logic even;
    logic pe;
    logic [2:0] err;
    logic [1:0] clksel;
    logic [1:0] stat;
    logic [1:0] mask;
    logic irq;
    logic [7:0] rdata;
    logic [7:0] rx_buf;
    logic rx_full;
    logic [7:0] tx_buf;
    logic tx_pend;
    scfm_tx_state_type tx_st;
    logic txd;
    logic sclk_o;
    logic sclk_oe;
    logic [10:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [15:0] tx_div;
    logic io_tx;
    logic io_rx;
    logic [7:0] io_in;
    logic [3:0] io_cnt;
    logic rxd_s1;
    logic rxd_s2;
    logic rxd_s3;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    scfm_rx_state_type rx_st;
    logic [15:0] rx_div;
    logic [3:0] rx_idx;
    logic [8:0] rx_sh;
  } scfm_state_type;

  localparam logic [15:0] BIT_LAST = 16'(BIT_CYC - 1);
  localparam logic [15:0] BIT_MID = 16'(BIT_CYC / 2 - 1);
  localparam logic [15:0] HALF_LAST = 16'(SCLK_HALF_CYC - 1);

  scfm_state_type s_q, s_d;

  // UART frame, LSB first: start, data, optional ninth or parity, stop
  function automatic logic [10:0] build_frame(input logic [7:0] d, input logic [1:0] sm,
                                              input logic pe, input logic even,
                                              input logic tb8);
    logic [10:0] f;
    logic [7:0] dd;
    logic par;
    f = 11'h7ff;
    dd = (sm == SCFM_SM_UART7) ? {1'b0, d[6:0]} : d;
    par = even ? ^dd : ~^dd;
    f[0] = 1'b0;
    if (sm == SCFM_SM_UART7) begin
      f[7:1] = dd[6:0];
      f[8] = pe ? par : 1'b1;
    end else begin
      f[8:1] = dd;
      if (sm == SCFM_SM_UART9) begin
        f[9] = tb8;
      end else begin
        f[9] = pe ? par : 1'b1;
      end
    end
    return f;
  endfunction : build_frame

  always_comb begin
    scfm_frame_mode_type sm;
    logic [3:0] nd;
    logic extra;
    logic is_io;
    logic fall_ev;
    logic rise_ev;
    logic [7:0] rdat;
    logic par_exp;
    logic [1:0] stat_set;
    logic [2:0] err_set;
    s_d = s_q;
    sm = scfm_frame_mode_type'(s_q.mode0[SCFM_M0_SM_HI:SCFM_M0_SM_LO]);
    is_io = (sm == SCFM_SM_IO);
    nd = (sm == SCFM_SM_UART7) ? 4'h7 : 4'h8;
    extra = (sm == SCFM_SM_UART9) | s_q.pe;
    fall_ev = 1'b0;
    rise_ev = 1'b0;
    rdat = SCFM_BYTE_RST;
    par_exp = 1'b0;
    stat_set = 2'b00;
    err_set = 3'b000;

    // Synchronisers; stage one feeds only stage two
    s_d.rxd_s1 = serial_in_pin;
    s_d.rxd_s2 = s_q.rxd_s1;
    s_d.rxd_s3 = s_q.rxd_s2;
    s_d.sclk_s1 = shift_clock_pin_i;
    s_d.sclk_s2 = s_q.sclk_s1;
    s_d.sclk_s3 = s_q.sclk_s2;

    // Shift clock is driven only in I/O mode with clock select 00
    s_d.sclk_oe = is_io && (s_q.clksel == 2'b00);

    // Transmit and I/O engine
    case (s_q.tx_st)
      SCFM_TX_IDLE: begin
        s_d.sclk_o = 1'b1;
        // Line returns high only after the last rise, never on it
        s_d.txd = 1'b1;
        if (is_io && (s_q.tx_pend ||
            (s_q.mode0[SCFM_M0_RXE] && !s_q.rx_full && !s_q.fdpx))) begin
          s_d.tx_st = SCFM_TX_IO;
          s_d.io_tx = s_q.tx_pend;
          s_d.io_rx = s_q.tx_pend ? (s_q.fdpx && s_q.mode0[SCFM_M0_RXE]) : 1'b1;
          s_d.tx_pend = 1'b0;
          s_d.tx_sh = {3'h7, s_q.tx_buf};
          s_d.io_cnt = 4'h0;
          s_d.tx_div = HALF_LAST;
        end else if (!is_io && s_q.tx_pend) begin
          s_d.tx_st = SCFM_TX_UART;
          s_d.tx_pend = 1'b0;
          s_d.tx_sh = build_frame(s_q.tx_buf, sm, s_q.pe, s_q.even, s_q.mode0[SCFM_M0_TB8]);
          s_d.txd = 1'b0;
          s_d.tx_sh = {1'b1, s_d.tx_sh[10:1]};
          s_d.tx_cnt = 4'(nd + {3'h0, extra} + 4'h1);
          s_d.tx_div = BIT_LAST;
        end
      end
      SCFM_TX_IO: begin
        if (s_q.clksel == 2'b00) begin
          if (s_q.tx_div == 16'h0) begin
            s_d.tx_div = HALF_LAST;
            s_d.sclk_o = ~s_q.sclk_o;
            fall_ev = s_q.sclk_o;
            rise_ev = ~s_q.sclk_o;
          end else begin
            s_d.tx_div = s_q.tx_div - 16'h1;
          end
        end else begin
          // External shift clock, edges seen after synchronising
          fall_ev = s_q.sclk_s3 & ~s_q.sclk_s2;
          rise_ev = ~s_q.sclk_s3 & s_q.sclk_s2;
        end
        if (fall_ev) begin
          s_d.txd = s_q.io_tx ? s_q.tx_sh[0] : 1'b1;
          s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
        end
        if (rise_ev) begin
          s_d.io_in = {s_q.rxd_s2, s_q.io_in[7:1]};
          s_d.io_cnt = s_q.io_cnt + 4'h1;
          if (s_q.io_cnt == 4'(SCFM_IO_BITS - 1)) begin
            s_d.tx_st = SCFM_TX_IDLE;
            stat_set[SCFM_IRQ_TX] = s_q.io_tx;
            if (s_q.io_rx) begin
              s_d.rx_buf = s_d.io_in;
              s_d.rx_full = 1'b1;
              stat_set[SCFM_IRQ_RX] = 1'b1;
              err_set[SCFM_ERR_OVR] = s_q.rx_full;
            end
          end
        end
      end
      SCFM_TX_UART: begin
        if (s_q.tx_div != 16'h0) begin
          s_d.tx_div = s_q.tx_div - 16'h1;
        end else if (s_q.tx_cnt == 4'h0) begin
          s_d.tx_st = SCFM_TX_IDLE;
          stat_set[SCFM_IRQ_TX] = 1'b1;
        end else begin
          s_d.txd = s_q.tx_sh[0];
          s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
          s_d.tx_cnt = s_q.tx_cnt - 4'h1;
          s_d.tx_div = BIT_LAST;
        end
      end
      default: begin
        s_d.tx_st = SCFM_TX_IDLE;
      end
    endcase

    // UART receiver, sampled at bit centres
    case (s_q.rx_st)
      SCFM_RX_IDLE: begin
        if (!is_io && s_q.mode0[SCFM_M0_RXE] && s_q.rxd_s3 && !s_q.rxd_s2) begin
          s_d.rx_st = SCFM_RX_START;
          s_d.rx_div = BIT_MID;
        end
      end
      SCFM_RX_START: begin
        if (s_q.rx_div != 16'h0) begin
          s_d.rx_div = s_q.rx_div - 16'h1;
        end else if (s_q.rxd_s2) begin
          s_d.rx_st = SCFM_RX_IDLE;
        end else begin
          s_d.rx_st = SCFM_RX_BITS;
          s_d.rx_idx = 4'h0;
          s_d.rx_sh = 9'h000;
          s_d.rx_div = BIT_LAST;
        end
      end
      SCFM_RX_BITS: begin
        if (s_q.rx_div != 16'h0) begin
          s_d.rx_div = s_q.rx_div - 16'h1;
        end else begin
          s_d.rx_sh[s_q.rx_idx] = s_q.rxd_s2;
          s_d.rx_idx = s_q.rx_idx + 4'h1;
          s_d.rx_div = BIT_LAST;
          if (s_q.rx_idx == 4'(nd + {3'h0, extra} - 4'h1)) begin
            s_d.rx_st = SCFM_RX_STOP;
          end
        end
      end
      SCFM_RX_STOP: begin
        if (s_q.rx_div != 16'h0) begin
          s_d.rx_div = s_q.rx_div - 16'h1;
        end else begin
          s_d.rx_st = SCFM_RX_IDLE;
          rdat = (sm == SCFM_SM_UART7) ? {1'b0, s_q.rx_sh[6:0]} : s_q.rx_sh[7:0];
          par_exp = s_q.even ? ^rdat : ~^rdat;
          if (sm == SCFM_SM_UART9) begin
            s_d.rb8 = s_q.rx_sh[8];
          end else if (s_q.pe) begin
            err_set[SCFM_ERR_PAR] = (s_q.rx_sh[nd] != par_exp);
          end
          err_set[SCFM_ERR_FRM] = ~s_q.rxd_s2;
          err_set[SCFM_ERR_OVR] = s_q.rx_full;
          s_d.rx_buf = rdat;
          s_d.rx_full = 1'b1;
          stat_set[SCFM_IRQ_RX] = 1'b1;
        end
      end
      default: begin
        s_d.rx_st = SCFM_RX_IDLE;
      end
    endcase

    // Register port; read data appears one cycle after the strobe
    if (bus_req.wr) begin
      case (bus_req.addr)
        SCFM_ADDR_MODE0: s_d.mode0 = bus_req.wdata;
        SCFM_ADDR_CTRL: begin
          s_d.even = bus_req.wdata[SCFM_CR_EVEN];
          s_d.pe = bus_req.wdata[SCFM_CR_PE];
          s_d.clksel = bus_req.wdata[1:0];
        end
        SCFM_ADDR_BUF: begin
          s_d.tx_buf = bus_req.wdata;
          s_d.tx_pend = 1'b1;
        end
        SCFM_ADDR_MODE1: s_d.fdpx = bus_req.wdata[SCFM_M1_FDPX];
        SCFM_ADDR_MASK: s_d.mask = bus_req.wdata[1:0];
        default: begin
        end
      endcase
    end
    s_d.rdata = SCFM_BYTE_RST;
    if (bus_req.rd) begin
      case (bus_req.addr)
        SCFM_ADDR_MODE0: s_d.rdata = s_q.mode0;
        SCFM_ADDR_CTRL: begin
          s_d.rdata = {s_q.rb8, s_q.even, s_q.pe, s_q.err, s_q.clksel};
          s_d.err = 3'b000;
        end
        SCFM_ADDR_BUF: begin
          s_d.rdata = s_q.rx_buf;
          s_d.rx_full = 1'b0;
        end
        SCFM_ADDR_MODE1: s_d.rdata = {1'b0, s_q.fdpx, 6'h00};
        SCFM_ADDR_STAT: begin
          s_d.rdata = {6'h00, s_q.stat};
          s_d.stat = 2'b00;
        end
        SCFM_ADDR_MASK: s_d.rdata = {6'h00, s_q.mask};
        default: s_d.rdata = SCFM_BYTE_RST;
      endcase
    end
    // Hardware set beats the read clear in the same cycle
    s_d.stat = s_d.stat | stat_set;
    s_d.err = s_d.err | err_set;
    if (stat_set[SCFM_IRQ_RX]) begin
      s_d.rx_full = 1'b1;
    end
    s_d.irq = |(s_d.stat & s_d.mask);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.mode0 <= SCFM_MODE0_RST;
      s_q.tx_st <= SCFM_TX_IDLE;
      s_q.rx_st <= SCFM_RX_IDLE;
      s_q.txd <= 1'b1;
      s_q.sclk_o <= 1'b1;
      s_q.sclk_oe <= 1'b1;
      s_q.rxd_s1 <= 1'b1;
      s_q.rxd_s2 <= 1'b1;
      s_q.rxd_s3 <= 1'b1;
      s_q.sclk_s1 <= 1'b1;
      s_q.sclk_s2 <= 1'b1;
      s_q.sclk_s3 <= 1'b1;
      s_q.tx_sh <= 11'h7ff;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rdata = s_q.rdata;
  assign irq = s_q.irq;
  assign serial_out_pin = s_q.txd;
  assign shift_clock_pin_o = s_q.sclk_o;
  assign shift_clock_pin_oe = s_q.sclk_oe;

endmodule : scfm_serial_channel

// ===== include/scfm_pkg.sv
package scfm_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] SCFM_ADDR_MODE0 = 3'h0;
  localparam logic [2:0] SCFM_ADDR_CTRL = 3'h1;
  localparam logic [2:0] SCFM_ADDR_BUF = 3'h2;
  localparam logic [2:0] SCFM_ADDR_MODE1 = 3'h3;
  localparam logic [2:0] SCFM_ADDR_STAT = 3'h4;
  localparam logic [2:0] SCFM_ADDR_MASK = 3'h5;

  // First mode register fields
  localparam int SCFM_M0_TB8 = 7;
  localparam int SCFM_M0_RXE = 5;
  localparam int SCFM_M0_SM_HI = 3;
  localparam int SCFM_M0_SM_LO = 2;
  // Second mode register field
  localparam int SCFM_M1_FDPX = 6;
  // Control register fields
  localparam int SCFM_CR_RB8 = 7;
  localparam int SCFM_CR_EVEN = 6;
  localparam int SCFM_CR_PE = 5;
  localparam int SCFM_CR_ERR_HI = 4;
  localparam int SCFM_CR_ERR_LO = 2;
  // Error field bit order within the three flags
  localparam int SCFM_ERR_OVR = 2;
  localparam int SCFM_ERR_PAR = 1;
  localparam int SCFM_ERR_FRM = 0;
  // Interrupt status and mask bits
  localparam int SCFM_IRQ_TX = 0;
  localparam int SCFM_IRQ_RX = 1;

  localparam logic [7:0] SCFM_MODE0_RST = 8'h00;
  localparam logic [7:0] SCFM_BYTE_RST = 8'h00;

  typedef enum logic [1:0] {
    SCFM_SM_IO = 2'b00,
    SCFM_SM_UART7 = 2'b01,
    SCFM_SM_UART8 = 2'b10,
    SCFM_SM_UART9 = 2'b11
  } scfm_frame_mode_type;

  typedef enum logic [1:0] {
    SCFM_TX_IDLE = 2'b00,
    SCFM_TX_IO = 2'b01,
    SCFM_TX_UART = 2'b10
  } scfm_tx_state_type;

  typedef enum logic [1:0] {
    SCFM_RX_IDLE = 2'b00,
    SCFM_RX_START = 2'b01,
    SCFM_RX_BITS = 2'b10,
    SCFM_RX_STOP = 2'b11
  } scfm_rx_state_type;

  // Timing: the divider is not modelled, bit times are fixed
  localparam int SCFM_CLK_PERIOD_NS = 4;
  localparam int SCFM_BIT_TIME_NS = 1000;
  localparam int SCFM_SCLK_HALF_NS = 500;
  localparam int SCFM_BIT_CYC = SCFM_BIT_TIME_NS / SCFM_CLK_PERIOD_NS;
  localparam int SCFM_SCLK_HALF_CYC = SCFM_SCLK_HALF_NS / SCFM_CLK_PERIOD_NS;
  localparam int SCFM_IO_BITS = 8;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scfm_bus_req_type;

endpackage : scfm_pkg

// ===== sim/scfm_serial_channel_asserts.sv
`timescale 1ns/1ps
module scfm_serial_channel_asserts
  import scfm_pkg::*;
#(
  parameter int BIT_CYC = 8,
  parameter int SCLK_HALF_CYC = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire scfm_bus_req_type bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic irq,
  input wire logic serial_out_pin,
  input wire logic serial_in_pin,
  input wire logic shift_clock_pin_i,
  input wire logic shift_clock_pin_o,
  input wire logic shift_clock_pin_oe
);
  logic [15:0] lo_q;
  logic [15:0] run_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Low-run counters measure half periods and bit times
  always_ff @(posedge clk_sys) begin
    lo_q <= (!nrst || shift_clock_pin_o) ? 16'h0000 : lo_q + 16'h0001;
    run_q <= (!nrst || serial_out_pin) ? 16'h0000 : run_q + 16'h0001;
  end
  a_rdata_idle:
    assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00) else $error("stray read data");
  a_rdata_unmapped:
    assert property ($past(bus_req.rd) && $past(bus_req.addr) > 3'h5 |-> bus_rdata == 8'h00)
      else $error("unmapped read not zero");
  a_data_rise_stable:
    assert property (shift_clock_pin_oe && $rose(shift_clock_pin_o) |-> $stable(serial_out_pin))
      else $error("data moved on sampling edge");
  a_sclk_low_time:
    assert property (shift_clock_pin_oe && $rose(shift_clock_pin_o)
      |-> lo_q == 16'(SCLK_HALF_CYC)) else $error("shift clock low time wrong");
  a_sclk_still:
    assert property (!shift_clock_pin_oe && !$past(shift_clock_pin_oe)
      |-> $stable(shift_clock_pin_o)) else $error("shift clock moved in uart mode");
  a_uart_bit_time:
    assert property (!shift_clock_pin_oe && $rose(serial_out_pin)
      |-> run_q % 16'(BIT_CYC) == 16'h0000) else $error("low run not whole bits");
  a_uart_no_sclk:
    assert property (bus_req.wr && bus_req.addr == SCFM_ADDR_MODE0 && bus_req.wdata[3:2] != 2'b00
      |-> ##[1:2] !shift_clock_pin_oe) else $error("shift clock driven in uart mode");
  a_irq_masked:
    assert property (bus_req.wr && bus_req.addr == SCFM_ADDR_MASK && bus_req.wdata == 8'h00
      |-> ##2 !irq) else $error("irq high with all masked");
  c_irq: cover property ($rose(irq));
  c_sclk: cover property (shift_clock_pin_oe && $rose(shift_clock_pin_o));
  c_uart: cover property (!shift_clock_pin_oe && $rose(serial_out_pin));
endmodule : scfm_serial_channel_asserts

bind scfm_serial_channel scfm_serial_channel_asserts #(
  .BIT_CYC(BIT_CYC), .SCLK_HALF_CYC(SCLK_HALF_CYC)
) i_scfm_serial_channel_asserts (
  .clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata), .irq(irq),
  .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin),
  .shift_clock_pin_i(shift_clock_pin_i), .shift_clock_pin_o(shift_clock_pin_o),
  .shift_clock_pin_oe(shift_clock_pin_oe)
);

// ===== sim/scfm_peer.sv
`timescale 1ns/1ps
module scfm_peer
  import scfm_pkg::*;
#(
  parameter int BIT_CYC = 8
) (
  input wire logic clk_sys,
  input wire logic serial_out_pin,
  input wire logic shift_clock_pin_o,
  input wire logic shift_clock_pin_oe,
  output logic serial_in_pin
);
  logic [7:0] sr_q = 8'hff;
  logic [7:0] io_n_q = 8'h00;
  logic [11:0] cap_q = 12'h000;
  logic bit_q = 1'b1;
  logic sck_q = 1'b1;
  // Remote uart echoes the line; shift register answers while the shift clock is driven
  assign serial_in_pin = shift_clock_pin_oe ? bit_q : serial_out_pin;
  always @(posedge clk_sys) begin
    sck_q <= shift_clock_pin_o;
    if (shift_clock_pin_oe && sck_q && !shift_clock_pin_o) begin
      bit_q <= sr_q[0];
    end
    if (shift_clock_pin_oe && !sck_q && shift_clock_pin_o) begin
      sr_q <= {serial_out_pin, sr_q[7:1]};
      io_n_q <= io_n_q + 8'h01;
    end
  end
  // Twelve centres cover the longest frame plus idle
  initial begin
    forever begin
      @(negedge serial_out_pin);
      if (!shift_clock_pin_oe) begin
        repeat (BIT_CYC / 2) @(negedge clk_sys);
        for (int i = 0; i < 12; i++) begin
          cap_q[i] = serial_out_pin;
          repeat (BIT_CYC) @(negedge clk_sys);
        end
      end
    end
  end
endmodule : scfm_peer

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import scfm_pkg::*;
  logic clk_sys, nrst, irq, txd, rxd, sco, scoe, sck_w;
  scfm_bus_req_type bus_req;
  logic [7:0] bus_rdata, rd_v;
  logic [12:0] c;
  int error_cnt, num_checks;
  // Case: frame mode, parity enable, even, ninth bit, byte
  logic [12:0] cs [6] = '{13'h082a, 13'h0e53, 13'h14c4, 13'h1081, 13'h1d3c, 13'h1af0};
  assign sck_w = scoe ? sco : 1'b1;
  scfm_serial_channel #(.BIT_CYC(8), .SCLK_HALF_CYC(4)) i_scfm_serial_channel (
    .clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata), .irq(irq),
    .serial_out_pin(txd), .serial_in_pin(rxd), .shift_clock_pin_i(sck_w),
    .shift_clock_pin_o(sco), .shift_clock_pin_oe(scoe));
  scfm_peer #(.BIT_CYC(8)) i_scfm_peer (.clk_sys(clk_sys), .serial_out_pin(txd),
    .shift_clock_pin_o(sco), .shift_clock_pin_oe(scoe), .serial_in_pin(rxd));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic compare(input logic [11:0] seen, input logic [11:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : compare
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk_sys);
    bus_req <= '0;
    @(negedge clk_sys);
    rd_v = bus_rdata;
    @(posedge clk_sys);
  endtask : acc
  task automatic rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    compare({4'h0, rd_v & m}, {4'h0, e & m}, "register");
  endtask : rc
  function automatic logic [11:0] frame(input logic [12:0] k);
    logic [11:0] f;
    int n;
    f = 12'hffe;
    n = (k[12:11] == 2'b01) ? 7 : 8;
    for (int i = 0; i < n; i++) f[i + 1] = k[i];
    if (k[12:11] == 2'b11) f[9] = k[8];
    else if (k[10]) f[n + 1] = ^(k[7:0] & (n == 7 ? 8'h7f : 8'hff)) ~^ k[9];
    return f;
  endfunction : frame
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #20000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    bus_req = '0;
    nrst = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rc(SCFM_ADDR_MODE0, 8'hff, SCFM_MODE0_RST);
    rc(SCFM_ADDR_BUF, 8'hff, SCFM_BYTE_RST);
    rc(3'h7, 8'hff, 8'h00);
    acc(1'b1, SCFM_ADDR_MASK, 8'h01);
    foreach (cs[k]) begin
      c = cs[k];
      acc(1'b1, SCFM_ADDR_CTRL, {1'b0, c[9], c[10], 5'h00});
      acc(1'b1, SCFM_ADDR_MODE0, {c[8], 2'b01, 1'b0, c[12:11], 2'b00});
      acc(1'b1, SCFM_ADDR_BUF, c[7:0]);
      for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge clk_sys);
      repeat (24) @(posedge clk_sys);
      compare(i_scfm_peer.cap_q, frame(c), "frame");
      compare(irq, 1'b1, "tx irq");
      rc(SCFM_ADDR_CTRL, c[12:11] == 2'b11 ? 8'h9c : 8'h1c, {c[8], 7'h00});
      rc(SCFM_ADDR_BUF, 8'hff, {c[12] & c[7], c[6:0]});
      rc(SCFM_ADDR_STAT, 8'h03, 8'h03);
      compare(irq, 1'b0, "irq cleared");
    end
    acc(1'b1, SCFM_ADDR_MASK, 8'h00);
    acc(1'b1, SCFM_ADDR_CTRL, 8'h00);
    acc(1'b1, SCFM_ADDR_MODE1, 8'h40);
    acc(1'b1, SCFM_ADDR_MODE0, 8'h20);
    i_scfm_peer.sr_q = 8'h96;
    i_scfm_peer.io_n_q = 8'h00;
    acc(1'b1, SCFM_ADDR_BUF, 8'ha5);
    for (int i = 0; i < 300 && i_scfm_peer.io_n_q < 8'h08; i++) @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
    compare(i_scfm_peer.io_n_q, 12'h008, "shift clocks");
    compare(i_scfm_peer.sr_q, 12'h0a5, "shifted out");
    compare(irq, 1'b0, "masked irq");
    acc(1'b1, SCFM_ADDR_MASK, 8'h02);
    compare(irq, 1'b1, "rx irq");
    rc(SCFM_ADDR_STAT, 8'h03, 8'h03);
    rc(SCFM_ADDR_BUF, 8'hff, 8'h96);
    compare(irq, 1'b0, "irq cleared");
    i_scfm_peer.sr_q = 8'h3c;
    acc(1'b1, SCFM_ADDR_MODE1, 8'h00);
    for (int i = 0; i < 300 && i_scfm_peer.io_n_q < 8'h10; i++) @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
    rc(SCFM_ADDR_STAT, 8'h03, 8'h02);
    rc(SCFM_ADDR_BUF, 8'hff, 8'h3c);
    report_and_stop();
  end
endmodule : tb_top
